// file: verilog/iosq_pkg.sv
package iosq_pkg;

  // bus and clock
  localparam int IOSQ_AW = 12;
  localparam int IOSQ_DW = 32;
  localparam longint IOSQ_CLK_PS = 100000;
  localparam longint IOSQ_TICK_PS = 15000;
  localparam int IOSQ_TICK_DIV =
    (IOSQ_TICK_PS / IOSQ_CLK_PS) < 1 ? 1 : int'(IOSQ_TICK_PS / IOSQ_CLK_PS);

  // strobe limits: times as printed, counts derived in ticks
  localparam longint IOSQ_STB_MIN_NS = 1000;
  localparam longint IOSQ_STB_MAX_S = 1;
  localparam longint IOSQ_STB_ON_MAX_MS = 100;
  localparam longint IOSQ_STB_MIN_TICKS =
    (IOSQ_STB_MIN_NS * 1000 + IOSQ_TICK_PS - 1) / IOSQ_TICK_PS;
  localparam longint IOSQ_STB_MAX_TICKS =
    (IOSQ_STB_MAX_S * 64'd1000000000000) / IOSQ_TICK_PS;
  localparam longint IOSQ_STB_ON_MAX_TICKS =
    (IOSQ_STB_ON_MAX_MS * 64'd1000000000) / IOSQ_TICK_PS;

  // sizes
  localparam int IOSQ_SLOTS = 16;
  localparam int IOSQ_FIELDS = 10;
  localparam int IOSQ_PWM_CH = 4;
  localparam int IOSQ_STB_CH = 4;
  localparam int IOSQ_NSRC = 25;
  localparam int IOSQ_NDST = 18;

  // register byte addresses
  localparam logic [11:0] IOSQ_A_CTRL = 12'h000;
  localparam logic [11:0] IOSQ_A_STATUS = 12'h004;
  localparam logic [11:0] IOSQ_A_SLOT_SEL = 12'h008;
  localparam logic [11:0] IOSQ_A_SLOT_CNT = 12'h00c;
  localparam logic [11:0] IOSQ_A_EXPO_DLY = 12'h010;
  localparam logic [11:0] IOSQ_A_STB_POL = 12'h014;
  localparam logic [11:0] IOSQ_A_STB_DLY = 12'h020;
  localparam logic [11:0] IOSQ_A_STB_DUR = 12'h030;
  localparam logic [11:0] IOSQ_A_SLOT = 12'h080;
  localparam logic [11:0] IOSQ_A_MUX = 12'h100;

  // control bits
  localparam int IOSQ_C_SEQ_EN = 0;
  localparam int IOSQ_C_SW_TRIG = 1;
  localparam int IOSQ_C_PRESC2 = 2;
  localparam int IOSQ_C_NV_SAVE = 3;
  localparam logic [3:0] IOSQ_CTRL_RST = 4'h0;
  localparam logic [4:0] IOSQ_SLOT_CNT_RST = 5'h01;

  // slot field indices
  localparam logic [3:0] IOSQ_F_INTERVAL = 4'h0;
  localparam logic [3:0] IOSQ_F_EXP_START = 4'h1;
  localparam logic [3:0] IOSQ_F_EXP_STOP = 4'h2;
  localparam logic [3:0] IOSQ_F_STB_START = 4'h3;
  localparam logic [3:0] IOSQ_F_STB_STOP = 4'h4;
  localparam logic [3:0] IOSQ_F_PWM_PERIOD = 4'h5;
  localparam logic [3:0] IOSQ_F_PWM_HIGH0 = 4'h6;

  // switch line fields
  localparam int IOSQ_M_INV = 8;
  localparam int IOSQ_M_FORCE = 9;

  // source indices
  localparam int IOSQ_S_STROBE0 = 6;
  localparam int IOSQ_S_STROBE1 = 7;
  localparam int IOSQ_S_PWM_A = 8;
  localparam int IOSQ_S_PWM_B = 9;
  localparam int IOSQ_S_PULSE_A = 12;
  localparam int IOSQ_S_PWM_C = 13;
  localparam int IOSQ_S_PWM_D = 14;
  localparam int IOSQ_S_ACTIVE = 15;
  localparam int IOSQ_S_DEBOUNCE = 16;
  localparam int IOSQ_S_PRESC = 17;
  localparam int IOSQ_S_PULSE_B = 18;
  localparam int IOSQ_S_LOGIC = 19;
  localparam int IOSQ_S_STROBE2 = 20;
  localparam int IOSQ_S_STROBE3 = 21;

  // destination indices
  localparam int IOSQ_D_TRIGGER = 6;
  localparam int IOSQ_D_SEQ_TRIG = 7;
  localparam int IOSQ_D_DEBOUNCE = 8;
  localparam int IOSQ_D_PRESC = 9;
  localparam int IOSQ_D_LOGIC_A = 10;
  localparam int IOSQ_D_LOGIC_B = 11;
  localparam int IOSQ_D_PULSE0 = 13;

  typedef struct packed {
    logic uart2_txd;
    logic trig_fb;
    logic mft_rxd;
    logic readout_in;
    logic expose_in;
    logic uart1_txd;
    logic io_rxd;
    logic [3:0] io_in;
  } iosq_pins_in_t;

  typedef logic [IOSQ_NDST-1:0] iosq_lines_t;

  typedef enum logic [1:0] {
    IOSQ_SEQ_IDLE = 2'b00,
    IOSQ_SEQ_RUN = 2'b01
  } iosq_seq_state_t;

  typedef enum logic [1:0] {
    IOSQ_PL_IDLE = 2'b00,
    IOSQ_PL_DELAY = 2'b01,
    IOSQ_PL_ON = 2'b11
  } iosq_pl_state_t;

endpackage : iosq_pkg

// file: verilog/iosq_top.sv
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module iosq_top #(
  parameter logic [31:0] P_STB_ON_MAX_TICKS =
    32'(iosq_pkg::IOSQ_STB_ON_MAX_TICKS),
  parameter logic [31:0] P_STB_MAX_TICKS = 32'(iosq_pkg::IOSQ_STB_MAX_TICKS)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [iosq_pkg::IOSQ_AW-1:0] paddr,
  input wire logic [iosq_pkg::IOSQ_DW-1:0] pwdata,
  output logic [iosq_pkg::IOSQ_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // external lines
  input wire iosq_pkg::iosq_pins_in_t pins_in,
  output iosq_pkg::iosq_lines_t lines_out,
  // sensor and storage
  output logic integ_start,
  output logic nv_save_req
);
  import iosq_pkg::*;

  // register state
  logic [3:0] ctrl;
  logic sw_trig;
  logic [3:0] slot_sel;
  logic [4:0] slot_cnt;
  logic [31:0] expo_dly;
  logic [IOSQ_STB_CH-1:0] stb_pol;
  logic [31:0] stb_dly [IOSQ_STB_CH];
  logic [31:0] stb_dur [IOSQ_STB_CH];
  logic [31:0] slot_mem [IOSQ_SLOTS][IOSQ_FIELDS];
  logic [9:0] mux_cfg [IOSQ_NDST];

  // datapath state
  logic tick_en;
  logic [7:0] tick_cnt;
  logic [IOSQ_NSRC-1:0] src;
  iosq_lines_t dest_q;
  iosq_lines_t dest_prev;
  logic [IOSQ_STB_CH-1:0] strobe_q;
  logic presc_q;
  logic presc_phase;
  logic presc_pass;
  logic debounce_q;
  logic logic_q;
  iosq_seq_state_t seq_state;
  logic [3:0] seq_slot;
  logic [31:0] seq_t;
  logic [31:0] pwm_t;
  logic seq_expose;
  logic seq_strobe;
  logic [IOSQ_PWM_CH-1:0] pwm_q;
  logic [31:0] expo_cnt;
  logic expo_busy;

  // apb decode
  logic acc;
  logic wr_en;
  logic [31:0] rd_data;
  logic rd_err;
  logic [11:0] slot_off;
  logic [11:0] mux_off;
  logic [3:0] fld;
  logic [4:0] mux_idx;
  logic hit_slot;
  logic hit_mux;
  logic [1:0] ch_idx;

  assign acc = psel & penable;
  assign wr_en = acc & pwrite & pready;
  assign slot_off = paddr - IOSQ_A_SLOT;
  assign mux_off = paddr - IOSQ_A_MUX;
  assign fld = slot_off[5:2];
  assign mux_idx = mux_off[6:2];
  assign hit_slot = paddr >= IOSQ_A_SLOT && paddr < IOSQ_A_MUX &&
    int'(fld) < IOSQ_FIELDS && slot_off[11:6] == 6'h00;
  assign hit_mux = paddr >= IOSQ_A_MUX && mux_off[11:7] == 5'h00 &&
    int'(mux_idx) < IOSQ_NDST;
  assign ch_idx = paddr[3:2];

  // read mux and unmapped detection
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (hit_slot) begin
      rd_data = slot_mem[slot_sel][fld];
    end else if (hit_mux) begin
      rd_data = {22'h00_0000, mux_cfg[mux_idx]};
    end else if (paddr[11:4] == IOSQ_A_STB_DLY[11:4]) begin
      rd_data = stb_dly[ch_idx];
    end else if (paddr[11:4] == IOSQ_A_STB_DUR[11:4]) begin
      rd_data = stb_dur[ch_idx];
    end else begin
      case (paddr)
        IOSQ_A_CTRL: rd_data = {28'h000_0000, ctrl};
        IOSQ_A_STATUS: rd_data = {20'h0_0000, strobe_q, seq_slot, 3'h0,
          seq_state == IOSQ_SEQ_RUN};
        IOSQ_A_SLOT_SEL: rd_data = {28'h000_0000, slot_sel};
        IOSQ_A_SLOT_CNT: rd_data = {27'h000_0000, slot_cnt};
        IOSQ_A_EXPO_DLY: rd_data = expo_dly;
        IOSQ_A_STB_POL: rd_data = {28'h000_0000, stb_pol};
        default: rd_err = 1'b1;
      endcase
    end
  end

  // apb answer after one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      if (acc & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= rd_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // global registers; command bits are single-cycle pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= IOSQ_CTRL_RST;
      sw_trig <= 1'b0;
      nv_save_req <= 1'b0;
      slot_sel <= 4'h0;
      slot_cnt <= IOSQ_SLOT_CNT_RST;
      expo_dly <= 32'h0000_0000;
      stb_pol <= 4'h0;
      for (int i = 0; i < IOSQ_STB_CH; i++) begin
        stb_dly[i] <= 32'h0000_0000;
        stb_dur[i] <= 32'h0000_0000;
      end
    end else begin
      sw_trig <= 1'b0;
      nv_save_req <= 1'b0;
      if (wr_en && !rd_err) begin
        case (paddr)
          IOSQ_A_CTRL: begin
            ctrl <= {1'b0, pwdata[IOSQ_C_PRESC2], 1'b0,
              pwdata[IOSQ_C_SEQ_EN]};
            sw_trig <= pwdata[IOSQ_C_SW_TRIG];
            nv_save_req <= pwdata[IOSQ_C_NV_SAVE];
          end
          IOSQ_A_SLOT_SEL: slot_sel <= pwdata[3:0];
          IOSQ_A_SLOT_CNT: begin
            if (pwdata[4:0] == 5'h00) begin
              slot_cnt <= 5'h01;
            end else if (pwdata[4:0] > 5'h10) begin
              slot_cnt <= 5'h10;
            end else begin
              slot_cnt <= pwdata[4:0];
            end
          end
          IOSQ_A_EXPO_DLY: expo_dly <= pwdata;
          IOSQ_A_STB_POL: stb_pol <= pwdata[3:0];
          default: begin
            if (paddr[11:4] == IOSQ_A_STB_DLY[11:4]) begin
              stb_dly[ch_idx] <= pwdata;
            end
            if (paddr[11:4] == IOSQ_A_STB_DUR[11:4]) begin
              stb_dur[ch_idx] <= pwdata;
            end
          end
        endcase
      end
    end
  end

  // slot storage written through slot select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int s = 0; s < IOSQ_SLOTS; s++) begin
        for (int f = 0; f < IOSQ_FIELDS; f++) begin
          slot_mem[s][f] <= 32'h0000_0000;
        end
      end
    end else if (wr_en && hit_slot) begin
      slot_mem[slot_sel][fld] <= pwdata;
    end
  end

  // switch line configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int d = 0; d < IOSQ_NDST; d++) begin
        mux_cfg[d] <= 10'h000;
      end
    end else if (wr_en && hit_mux) begin
      mux_cfg[mux_idx] <= {pwdata[IOSQ_M_FORCE], pwdata[IOSQ_M_INV],
        3'h0, pwdata[4:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 8'h00;
      tick_en <= 1'b0;
    end else if (int'(tick_cnt) >= IOSQ_TICK_DIV - 1) begin
      tick_cnt <= 8'h00;
      tick_en <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
      tick_en <= 1'b0;
    end
  end

  // source vector feeding the matrix
  always_comb begin
    src = '0;
    src[3:0] = pins_in.io_in;
    src[4] = pins_in.io_rxd;
    src[5] = pins_in.uart1_txd;
    src[IOSQ_S_STROBE0] = strobe_q[0];
    src[IOSQ_S_STROBE1] = strobe_q[1];
    src[IOSQ_S_STROBE2] = strobe_q[2];
    src[IOSQ_S_STROBE3] = strobe_q[3];
    src[IOSQ_S_PWM_A] = pwm_q[0];
    src[IOSQ_S_PWM_B] = pwm_q[1];
    src[10] = pins_in.expose_in;
    src[11] = pins_in.readout_in;
    src[IOSQ_S_PULSE_A] = seq_expose;
    src[IOSQ_S_PWM_C] = pwm_q[2];
    src[IOSQ_S_PWM_D] = pwm_q[3];
    src[IOSQ_S_ACTIVE] = seq_state == IOSQ_SEQ_RUN;
    src[IOSQ_S_DEBOUNCE] = debounce_q;
    src[IOSQ_S_PRESC] = presc_q;
    src[IOSQ_S_PULSE_B] = seq_strobe;
    src[IOSQ_S_LOGIC] = logic_q;
    src[22] = pins_in.mft_rxd;
    src[23] = pins_in.trig_fb;
    src[24] = pins_in.uart2_txd;
  end

  // registered switch matrix with invert and force
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest_q <= '0;
      dest_prev <= '0;
    end else begin
      dest_prev <= dest_q;
      for (int d = 0; d < IOSQ_NDST; d++) begin
        if (mux_cfg[d][IOSQ_M_FORCE]) begin
          // force high, inverted force gives low
          dest_q[d] <= ~mux_cfg[d][IOSQ_M_INV];
        end else if (int'(mux_cfg[d][4:0]) < IOSQ_NSRC) begin
          dest_q[d] <= src[mux_cfg[d][4:0]] ^ mux_cfg[d][IOSQ_M_INV];
        end else begin
          dest_q[d] <= mux_cfg[d][IOSQ_M_INV];
        end
      end
    end
  end

  assign lines_out = dest_q;

  // helper modules: debounce stage and logic result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debounce_q <= 1'b0;
      logic_q <= 1'b0;
    end else begin
      debounce_q <= dest_q[IOSQ_D_DEBOUNCE];
      logic_q <= dest_q[IOSQ_D_LOGIC_A] & dest_q[IOSQ_D_LOGIC_B];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_phase <= 1'b0;
      presc_pass <= 1'b0;
      presc_q <= 1'b0;
    end else if (!ctrl[IOSQ_C_PRESC2]) begin
      presc_phase <= 1'b0;
      presc_pass <= 1'b1;
      presc_q <= dest_q[IOSQ_D_PRESC];
    end else if (dest_q[IOSQ_D_PRESC] && !dest_prev[IOSQ_D_PRESC]) begin
      presc_phase <= ~presc_phase;
      presc_pass <= presc_phase;
      presc_q <= presc_phase;
    end else begin
      presc_q <= dest_q[IOSQ_D_PRESC] & presc_pass;
    end
  end

  for (genvar k = 0; k < IOSQ_STB_CH; k++) begin : g_pl
    iosq_pl_state_t pl_state;
    logic [31:0] pl_cnt;
    logic [31:0] pl_len;
    logic pl_rise;

    assign pl_rise = dest_q[IOSQ_D_PULSE0 + k] &
      ~dest_prev[IOSQ_D_PULSE0 + k];

    always_comb begin
      pl_len = stb_dur[k];
      if (pl_len < 32'(IOSQ_STB_MIN_TICKS)) begin
        pl_len = 32'(IOSQ_STB_MIN_TICKS);
      end
      if (pl_len > P_STB_MAX_TICKS) begin
        pl_len = P_STB_MAX_TICKS;
      end
      if (pl_len > P_STB_ON_MAX_TICKS) begin
        pl_len = P_STB_ON_MAX_TICKS;
      end
    end

    // delay from trigger edge then pulse
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pl_state <= IOSQ_PL_IDLE;
        pl_cnt <= 32'h0000_0000;
        strobe_q[k] <= 1'b0;
      end else begin
        case (pl_state)
          IOSQ_PL_IDLE: begin
            strobe_q[k] <= stb_pol[k];
            if (pl_rise) begin
              pl_state <= IOSQ_PL_DELAY;
              pl_cnt <= stb_dly[k];
            end
          end
          IOSQ_PL_DELAY: begin
            if (pl_cnt == 32'h0000_0000) begin
              pl_state <= IOSQ_PL_ON;
              pl_cnt <= pl_len - 32'h0000_0001;
              strobe_q[k] <= ~stb_pol[k];
            end else if (tick_en) begin
              pl_cnt <= pl_cnt - 32'h0000_0001;
            end
          end
          IOSQ_PL_ON: begin
            if (pl_cnt == 32'h0000_0000) begin
              pl_state <= IOSQ_PL_IDLE;
              strobe_q[k] <= stb_pol[k];
            end else if (tick_en) begin
              pl_cnt <= pl_cnt - 32'h0000_0001;
            end
          end
          default: begin
            pl_state <= IOSQ_PL_IDLE;
            strobe_q[k] <= stb_pol[k];
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expo_busy <= 1'b0;
      expo_cnt <= 32'h0000_0000;
      integ_start <= 1'b0;
    end else begin
      integ_start <= 1'b0;
      if (!expo_busy) begin
        if (dest_q[IOSQ_D_TRIGGER] && !dest_prev[IOSQ_D_TRIGGER]) begin
          expo_busy <= 1'b1;
          expo_cnt <= expo_dly;
        end
      end else if (expo_cnt == 32'h0000_0000) begin
        expo_busy <= 1'b0;
        integ_start <= 1'b1;
      end else if (tick_en) begin
        expo_cnt <= expo_cnt - 32'h0000_0001;
      end
    end
  end

  // sequencer stepping through the programmed intervals
  logic seq_trig;
  logic [31:0] cur_len;
  assign seq_trig = ctrl[IOSQ_C_SEQ_EN] & (sw_trig |
    (dest_q[IOSQ_D_SEQ_TRIG] & ~dest_prev[IOSQ_D_SEQ_TRIG]));
  assign cur_len = slot_mem[seq_slot][IOSQ_F_INTERVAL];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_state <= IOSQ_SEQ_IDLE;
      seq_slot <= 4'h0;
      seq_t <= 32'h0000_0000;
      pwm_t <= 32'h0000_0000;
    end else begin
      case (seq_state)
        IOSQ_SEQ_IDLE: begin
          seq_slot <= 4'h0;
          seq_t <= 32'h0000_0000;
          pwm_t <= 32'h0000_0000;
          if (seq_trig) begin
            seq_state <= IOSQ_SEQ_RUN;
          end
        end
        IOSQ_SEQ_RUN: begin
          if (!ctrl[IOSQ_C_SEQ_EN]) begin
            seq_state <= IOSQ_SEQ_IDLE;
          end else if (tick_en) begin
            if (seq_t + 32'h0000_0001 >= cur_len) begin
              seq_t <= 32'h0000_0000;
              pwm_t <= 32'h0000_0000;
              if ({1'b0, seq_slot} + 5'h01 >= slot_cnt) begin
                // back to idle after last interval
                seq_state <= IOSQ_SEQ_IDLE;
              end else begin
                seq_slot <= seq_slot + 4'h1;
              end
            end else begin
              seq_t <= seq_t + 32'h0000_0001;
              if (pwm_t + 32'h0000_0001 >=
                  slot_mem[seq_slot][IOSQ_F_PWM_PERIOD]) begin
                pwm_t <= 32'h0000_0000;
              end else begin
                pwm_t <= pwm_t + 32'h0000_0001;
              end
            end
          end
        end
        default: seq_state <= IOSQ_SEQ_IDLE;
      endcase
    end
  end

  // interval windows and pwm outputs, low while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_expose <= 1'b0;
      seq_strobe <= 1'b0;
      pwm_q <= '0;
    end else if (seq_state != IOSQ_SEQ_RUN) begin
      seq_expose <= 1'b0;
      seq_strobe <= 1'b0;
      pwm_q <= '0;
    end else begin
      seq_expose <= seq_t >= slot_mem[seq_slot][IOSQ_F_EXP_START] &&
        seq_t < slot_mem[seq_slot][IOSQ_F_EXP_STOP];
      seq_strobe <= seq_t >= slot_mem[seq_slot][IOSQ_F_STB_START] &&
        seq_t < slot_mem[seq_slot][IOSQ_F_STB_STOP];
      for (int c = 0; c < IOSQ_PWM_CH; c++) begin
        // duty from high time, full on and off
        pwm_q[c] <= pwm_t <
          slot_mem[seq_slot][IOSQ_F_PWM_HIGH0 + 4'(c)] ||
          slot_mem[seq_slot][IOSQ_F_PWM_HIGH0 + 4'(c)] >=
          slot_mem[seq_slot][IOSQ_F_PWM_PERIOD] &&
          slot_mem[seq_slot][IOSQ_F_PWM_HIGH0 + 4'(c)] != 32'h0000_0000;
      end
    end
  end

endmodule : iosq_top

// file: test/iosq_partner.sv
`timescale 1ns/1ps
module iosq_partner (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // trigger levels from the bench and one led line
  input wire logic [3:0] trig,
  input wire logic led,
  // camera pins and length of the last led on period
  output iosq_pkg::iosq_pins_in_t pins_in,
  output logic [15:0] on_len
);
  import iosq_pkg::*;
  logic [15:0] run;
  logic led_q;
  // trigger sources drive the inputs, unused pins idle low
  assign pins_in = {7'h00, trig};
  // light model: counts cycles of each on period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= '0;
      led_q <= 1'b0;
      on_len <= '0;
    end else begin
      led_q <= led;
      run <= led ? run + 16'd1 : 16'd0;
      if (led && !led_q) on_len <= '0;
      if (!led && led_q) on_len <= run;
    end
  end
endmodule : iosq_partner

// file: test/iosq_properties.sv
`timescale 1ns/1ps
module iosq_props #(
  parameter logic [31:0] P_STB_ON_MAX_TICKS = 32'd50,
  parameter logic [31:0] P_STB_MAX_TICKS = 32'd100
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [iosq_pkg::IOSQ_AW-1:0] paddr,
  input wire logic [iosq_pkg::IOSQ_DW-1:0] pwdata,
  input wire logic [iosq_pkg::IOSQ_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // external lines
  input wire iosq_pkg::iosq_pins_in_t pins_in,
  input wire iosq_pkg::iosq_lines_t lines_out,
  // sensor and storage
  input wire logic integ_start,
  input wire logic nv_save_req
);
  import iosq_pkg::*;
  logic [9:0] m0;
  logic [1:0] age;
  logic exp0;
  logic ok;
  logic wr_ok;
  logic nv_wr;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // accepted writes and a settled line 0 setup from pin 0
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign nv_wr = wr_ok && paddr == IOSQ_A_CTRL && pwdata[IOSQ_C_NV_SAVE];
  assign ok = age == 2'd3 && (m0[4:0] == 5'h00 || m0[IOSQ_M_FORCE]);
  // shadow of line 0 setup, age saturates at three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m0 <= '0;
      age <= '0;
    end else if (wr_ok && paddr == IOSQ_A_MUX) begin
      m0 <= pwdata[9:0];
      age <= '0;
    end else if (age != 2'd3) begin
      age <= age + 2'd1;
    end
  end
  // expected line 0 level: force gives high, then invert
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) exp0 <= 1'b0;
    else exp0 <= m0[IOSQ_M_INV] ^ (m0[IOSQ_M_FORCE] | pins_in.io_in[0]);
  end
  sequence s_wait;
    !pready ##1 pready;
  endsequence
  property p_one_wait;
    psel && $rose(penable) |-> s_wait;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err;
    pslverr |-> pready && prdata == '0;
  endproperty
  property p_nv_pulse;
    nv_save_req |=> !nv_save_req;
  endproperty
  property p_nv_cause;
    $rose(nv_save_req) |-> $past(nv_wr) || $past(nv_wr, 2);
  endproperty
  property p_integ_pulse;
    integ_start |=> !integ_start;
  endproperty
  property p_pass;
    ok && m0[9:8] == 2'b00 |-> lines_out[0] == exp0;
  endproperty
  property p_inv;
    ok && m0[9:8] == 2'b01 |-> lines_out[0] == exp0;
  endproperty
  property p_force;
    ok && m0[9:8] == 2'b10 |-> lines_out[0];
  endproperty
  property p_force_inv;
    ok && m0[9:8] == 2'b11 |-> !lines_out[0];
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("apb answer not after one wait");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_err: assert property (p_err)
    else $error("error answer malformed");
  a_nv_pulse: assert property (p_nv_pulse)
    else $error("save request longer than one cycle");
  a_nv_cause: assert property (p_nv_cause)
    else $error("save request without write");
  a_integ_pulse: assert property (p_integ_pulse)
    else $error("integration start longer than one cycle");
  a_pass: assert property (p_pass)
    else $error("line 0 not following source");
  a_inv: assert property (p_inv)
    else $error("line 0 not inverted");
  a_force: assert property (p_force)
    else $error("line 0 not forced high");
  a_force_inv: assert property (p_force_inv)
    else $error("line 0 not forced low");
endmodule : iosq_props
bind iosq_top iosq_props #(
  .P_STB_ON_MAX_TICKS(P_STB_ON_MAX_TICKS),
  .P_STB_MAX_TICKS(P_STB_MAX_TICKS)
) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
  .lines_out(lines_out), .integ_start(integ_start),
  .nv_save_req(nv_save_req)
);

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import iosq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic integ_start, nv_save_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] trig;
  logic [15:0] on_len;
  iosq_pins_in_t pins_in;
  iosq_lines_t lines_out;
  int n_fail, checks_done, cyc, n;
  logic [31:0] sf [8] = '{40, 10, 20, 5, 30, 10, 3, 12};
  logic [31:0] src [4] = '{12, 18, 8, 9};
  logic [31:0] len [4] = '{10, 25, 3, 40};
  logic [31:0] dur [3] = '{10, 70, 200};
  logic [31:0] lo [3] = '{67, 70, 80};
  iosq_top #(.P_STB_ON_MAX_TICKS(32'd80), .P_STB_MAX_TICKS(32'd100)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pins_in),
    .lines_out(lines_out), .integ_start(integ_start),
    .nv_save_req(nv_save_req)
  );
  iosq_partner u_partner (
    .pclk(pclk), .presetn(presetn), .trig(trig), .led(lines_out[0]),
    .pins_in(pins_in), .on_len(on_len)
  );
  // one apb transfer, answer taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) n_fail++;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic test_done;
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  always #50 pclk = ~pclk;
  // run limit guards a hung handshake
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; trig = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IOSQ_A_SLOT_CNT, 0);
    chk("slot_cnt", 1, rv);
    wr(IOSQ_A_SLOT_CNT, 20);
    apb(1'b0, IOSQ_A_SLOT_CNT, 0);
    chk("slot_max", 16, rv);
    wr(IOSQ_A_SLOT_CNT, 1);
    apb(1'b0, 12'hffc, 0);
    chk("unmapped", 1, re);
    // all four invert and force settings on line 0
    for (int k = 0; k < 4; k++) begin
      wr(IOSQ_A_MUX, {22'h0, k[1:0], 8'h00});
      for (int p = 0; p < 2; p++) begin
        @(posedge pclk);
        trig[0] <= p[0];
        repeat (4) @(negedge pclk);
        chk("line0", k[0] ^ (k[1] | p[0]), lines_out[0]);
      end
    end
    // trigger low and pulse loop 0 back to idle before the strobe runs
    @(posedge pclk);
    trig[0] <= 1'b0;
    repeat (100) @(negedge pclk);
    // strobe durations clamped, integration delay
    wr(IOSQ_A_MUX, IOSQ_S_STROBE0);
    wr(IOSQ_A_STB_DLY, 5);
    wr(IOSQ_A_EXPO_DLY, 8);
    foreach (dur[i]) begin
      wr(IOSQ_A_STB_DUR, dur[i]);
      @(posedge pclk);
      trig[0] <= 1'b1;
      n = 0;
      while (integ_start !== 1'b1 && n < 40) begin
        @(negedge pclk);
        n++;
      end
      chk("integ_dly", 1, n > 8 && n < 14);
      @(posedge pclk);
      trig[0] <= 1'b0;
      repeat (150) @(negedge pclk);
      chk("strobe_len", 1, on_len >= lo[i] && on_len <= lo[i] + 1);
    end
    wr(IOSQ_A_STB_POL, 1);
    repeat (4) @(negedge pclk);
    chk("strobe_pol", 1, lines_out[0]);
    // one slot: exposure, strobe and two pwm channels
    // exposure stop 20 stays inside the 40 tick interval
    foreach (sf[f]) wr(IOSQ_A_SLOT + 12'(4 * f), sf[f]);
    foreach (src[i]) begin
      wr(IOSQ_A_MUX, src[i]);
      wr(IOSQ_A_CTRL, 3);
      repeat (60) @(negedge pclk);
      chk("seq_len", len[i], on_len);
      chk("seq_idle", 0, lines_out[0]);
    end
    // two slots of 40 ticks run back to back on the active source
    wr(IOSQ_A_SLOT_SEL, 1);
    foreach (sf[f]) wr(IOSQ_A_SLOT + 12'(4 * f), sf[f]);
    wr(IOSQ_A_SLOT_CNT, 2);
    wr(IOSQ_A_MUX, IOSQ_S_ACTIVE);
    wr(IOSQ_A_CTRL, 3);
    repeat (100) @(negedge pclk);
    chk("seq_two", 80, on_len);
    // prescaler on line 0 passes only the second trigger pulse
    wr(IOSQ_A_MUX, IOSQ_S_PRESC);
    wr(IOSQ_A_CTRL, 4);
    for (int p = 0; p < 2; p++) begin
      @(posedge pclk);
      trig[0] <= 1'b1;
      repeat (4) @(negedge pclk);
      chk("presc", p, lines_out[0]);
      @(posedge pclk);
      trig[0] <= 1'b0;
      repeat (4) @(negedge pclk);
    end
    wr(IOSQ_A_CTRL, 8);
    n = 0;
    while (nv_save_req !== 1'b1 && n < 5) begin
      @(negedge pclk);
      n++;
    end
    chk("nv_save", 1, nv_save_req);
    test_done();
  end
endmodule : testbench
